// [hw/qa_watchdog_answer_evaluator.sv]
// q&a watchdog multi-answer evaluator: tallies answers and decides each cycle's end
`timescale 1ns/100ps
// Summary of operation
// - four answers with under three in window one end the cycle at once
// - such an early end increments failures, repeats question, sets watchdog error
// - all values correct but misplaced: answer error stays 0, watchdog error set
// - under four answers at second window close: end, increment failures, same question
// - incorrect answer in window one, short cycle: both error flags set
// - incorrect answers in window two after short window one: watchdog error, fail
// - only incorrect answers, under four: both flags, increment, repeat at close
// - three correct then one correct: decrement failures, new question, flags keep their value
module qa_watchdog_answer_evaluator #(
  parameter int unsigned ANSWERS = qa_eval_pkg::ANSWERS_PER_CYCLE,
  parameter int unsigned QUOTA   = qa_eval_pkg::FIRST_WINDOW_QUOTA,
  parameter int unsigned WIDTH   = qa_eval_pkg::TALLY_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             answer_strobe,
  input  wire logic             answer_correct,
  input  wire logic             first_response_window,
  input  wire logic             second_window_end,
  input  wire logic             flag_clear,
  output logic [WIDTH-1:0]      answer_count,
  output logic                  answer_error_flag,
  output logic                  watchdog_error_flag,
  output logic                  cycle_end,
  output logic                  fail_count_up,
  output logic                  fail_count_down,
  output logic                  new_question,
  output logic                  same_question
);
  // ****************************************************
  // elaboration checks
  // ****************************************************
  // separate checks so the message names the offending parameter
  if (ANSWERS < 2) begin : gen_answers_check
    $error("qa_watchdog_answer_evaluator: ANSWERS must be at least 2");
  end
  // the correct sequence needs at least one answer in window two
  if (QUOTA >= ANSWERS) begin : gen_quota_check
    $error("qa_watchdog_answer_evaluator: QUOTA must be below ANSWERS");
  end
  // the tally must hold the value ANSWERS itself without wrapping
  if (ANSWERS >= (1 << WIDTH)) begin : gen_width_check
    $error("qa_watchdog_answer_evaluator: WIDTH too narrow for ANSWERS");
  end

  // ****************************************************
  // decoding helpers
  // ****************************************************
  // an answer that the host got wrong in value
  function automatic logic wrong_answer(
    input logic strobe,
    input logic correct
  );
    return strobe && !correct;
  endfunction

  // any cycle end other than the one correct sequence is a failure
  function automatic logic failed_end(
    input logic ended,
    input logic good
  );
    return ended && !good;
  endfunction

  // ****************************************************
  // per-cycle tallies
  // ****************************************************
  // compare values held at tally width
  localparam logic [WIDTH-1:0] LAST_INDEX = WIDTH'(ANSWERS - 1);
  localparam logic [WIDTH-1:0] QUOTA_CNT  = WIDTH'(QUOTA);

  // per-cycle state
  logic [WIDTH-1:0] total_count;
  logic [WIDTH-1:0] first_count;
  logic             wrong_seen;

  // decision terms, all combinational
  logic             end_now;
  logic             fourth_answer;
  logic             wrong_final;
  logic             sequence_good;

  // ****************************************************
  // cycle decision
  // ****************************************************
  // fourth answer closes the cycle at once
  assign fourth_answer = answer_strobe && (total_count == LAST_INDEX);
  // the fourth answer wins over a coincident window close
  assign end_now       = fourth_answer || second_window_end;
  // a wrong value anywhere in the cycle, this answer included
  assign wrong_final   = wrong_seen || wrong_answer(answer_strobe, answer_correct);
  // only three in window one then one in window two, all correct, passes
  assign sequence_good = fourth_answer
                         && !first_response_window
                         && (first_count == QUOTA_CNT)
                         && !wrong_final;

  // ****************************************************
  // answer tallies
  // ****************************************************
  // tallies cleared
  answer_tally #(
    .WIDTH     (WIDTH)
  ) total_tally (
    .clock     (clock),
    .reset     (reset),
    .clear     (end_now),
    .increment (answer_strobe),
    .count     (total_count)
  );

  answer_tally #(
    .WIDTH     (WIDTH)
  ) first_tally (
    .clock     (clock),
    .reset     (reset),
    .clear     (end_now),
    .increment (answer_strobe && first_response_window),
    .count     (first_count)
  );

  always_ff @(posedge clock) begin
    if (reset || end_now) begin
      wrong_seen <= qa_eval_pkg::FLAG_RESET;
    end else if (wrong_answer(answer_strobe, answer_correct)) begin
      wrong_seen <= 1'b1;
    end
  end

  // ****************************************************
  // answer count output
  // ****************************************************
  // zero again at the edge that ends a cycle
  // saturation never bites: the fourth answer always ends the cycle first
  always_ff @(posedge clock) begin
    if (reset || end_now) begin
      answer_count <= '0;
    end else if (answer_strobe && (answer_count != {WIDTH{1'b1}})) begin
      answer_count <= answer_count + WIDTH'(1);
    end
  end

  // ****************************************************
  // cycle outcome pulses
  // ****************************************************
  // cycle end on fourth answer or second window close
  always_ff @(posedge clock) begin
    if (reset) begin
      cycle_end <= qa_eval_pkg::PULSE_RESET;
    end else begin
      cycle_end <= end_now;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fail_count_up <= qa_eval_pkg::PULSE_RESET;
    end else begin
      fail_count_up <= failed_end(end_now, sequence_good);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      same_question <= qa_eval_pkg::PULSE_RESET;
    end else begin
      same_question <= failed_end(end_now, sequence_good);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fail_count_down <= qa_eval_pkg::PULSE_RESET;
    end else begin
      fail_count_down <= sequence_good;
    end
  end

  // correct sequence takes a new question
  always_ff @(posedge clock) begin
    if (reset) begin
      new_question <= qa_eval_pkg::PULSE_RESET;
    end else begin
      new_question <= sequence_good;
    end
  end

  // ****************************************************
  // watchdog error flag
  // ****************************************************
  // set on any failed cycle; set beats a coincident clear
  always_ff @(posedge clock) begin
    if (reset) begin
      watchdog_error_flag <= qa_eval_pkg::FLAG_RESET;
    end else if (failed_end(end_now, sequence_good)) begin
      watchdog_error_flag <= 1'b1;
    end else if (flag_clear) begin
      watchdog_error_flag <= 1'b0;
    end
  end

  // ****************************************************
  // answer error flag
  // ****************************************************
  // set only for wrong values, so misplaced answers leave it at 0
  always_ff @(posedge clock) begin
    if (reset) begin
      answer_error_flag <= qa_eval_pkg::FLAG_RESET;
    end else if (end_now && wrong_final) begin
      answer_error_flag <= 1'b1;
    end else if (flag_clear) begin
      answer_error_flag <= 1'b0;
    end
  end
endmodule

// [hw/qa_eval_pkg.sv]
// constants shared by the q&a answer evaluator files
package qa_eval_pkg;
  // answers that close a watchdog cycle early
  localparam int unsigned ANSWERS_PER_CYCLE  = 4;
  // answers expected in the first response window
  localparam int unsigned FIRST_WINDOW_QUOTA = 3;
  // width of the answer tallies, wide enough for a full cycle
  localparam int unsigned TALLY_WIDTH        = 3;
  // values after reset
  localparam logic        FLAG_RESET         = 1'b0;
  localparam logic        PULSE_RESET        = 1'b0;
endpackage

// [hw/answer_tally.sv]
// saturating answer tally with clear taking priority
`timescale 1ns/100ps
module answer_tally #(
  parameter int unsigned WIDTH = qa_eval_pkg::TALLY_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic             increment,
  output logic [WIDTH-1:0]      count
);
  // a zero-width tally could not count at all
  if (WIDTH < 1) begin : gen_width_check
    $error("answer_tally: WIDTH must be at least 1");
  end

  // clear wins: a cycle boundary discards a coincident answer count
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      count <= '0;
    end else if (increment && (count != {WIDTH{1'b1}})) begin
      count <= count + WIDTH'(1);
    end
  end
endmodule

// [sim/qa_eval_props.sv]
// port assertions for the answer evaluator
`timescale 1ns/100ps
module qa_eval_checker #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             answer_strobe,
  input  wire logic             answer_correct,
  input  wire logic             first_response_window,
  input  wire logic             second_window_end,
  input  wire logic             flag_clear,
  input  wire logic             answer_error_flag,
  input  wire logic             watchdog_error_flag,
  input  wire logic             cycle_end,
  input  wire logic             fail_count_up,
  input  wire logic             fail_count_down,
  input  wire logic             new_question,
  input  wire logic             same_question,
  input  wire logic [WIDTH-1:0] answer_count
);
  // ****************************************************
  // cycle end and correct answers as seen from the ports
  // ****************************************************
  logic end_event;
  logic right_seen;
  assign end_event = second_window_end || (answer_strobe && answer_count == 3);
  always_ff @(posedge clock) begin
    if (reset || end_event) begin
      right_seen <= 1'b0;
    end else if (answer_strobe && answer_correct) begin
      right_seen <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_FOURTH_END: assert property (answer_strobe && answer_count == 3 |=> cycle_end)
    else $error("no end after fourth answer");
  AST_CLOSE_END: assert property (second_window_end |=> cycle_end)
    else $error("no end at window close");
  AST_UP_DOWN: assert property (cycle_end |-> fail_count_up != fail_count_down)
    else $error("bad failure counter step");
  AST_QSEL: assert property (
    cycle_end |-> same_question == fail_count_up && new_question == fail_count_down)
    else $error("bad question select");
  AST_QUIET: assert property (
    !cycle_end |-> !(fail_count_up || fail_count_down || new_question || same_question))
    else $error("pulse outside cycle end");
  AST_CLEAR: assert property (cycle_end |-> answer_count == 0)
    else $error("count not cleared");
  AST_WRONG_AERR: assert property (
    answer_strobe && !answer_correct && answer_count == 3 |=> answer_error_flag)
    else $error("answer error not set");
  AST_WERR_CAUSE: assert property ($rose(watchdog_error_flag) |-> fail_count_up)
    else $error("watchdog error without failure");
  AST_ONLY_WRONG: assert property (
    second_window_end && !answer_strobe && answer_count != 0 && !right_seen
    |=> answer_error_flag && watchdog_error_flag && fail_count_up && same_question)
    else $error("only wrong answers not flagged");
endmodule
bind qa_watchdog_answer_evaluator qa_eval_checker #(
  .WIDTH                 (WIDTH)
) qa_eval_checker_inst (
  .clock                 (clock),
  .reset                 (reset),
  .answer_strobe         (answer_strobe),
  .answer_correct        (answer_correct),
  .first_response_window (first_response_window),
  .second_window_end     (second_window_end),
  .flag_clear            (flag_clear),
  .answer_error_flag     (answer_error_flag),
  .watchdog_error_flag   (watchdog_error_flag),
  .cycle_end             (cycle_end),
  .fail_count_up         (fail_count_up),
  .fail_count_down       (fail_count_down),
  .new_question          (new_question),
  .same_question         (same_question),
  .answer_count          (answer_count)
);

// [sim/host_model.sv]
// host model answering watchdog questions
`timescale 1ns/100ps
module host_model (
  input  wire logic clock,
  output logic      answer_strobe = 1'b0,
  output logic      answer_correct = 1'b0,
  output logic      first_response_window = 1'b0
);
  task automatic send(input logic ok, input logic win);
    @(posedge clock) #1;
    {answer_strobe, answer_correct, first_response_window} = {1'b1, ok, win};
    @(posedge clock) #1;
    // released qualifiers show the inverse, not a stale value
    {answer_strobe, answer_correct, first_response_window} = {1'b0, !ok, !win};
  endtask
endmodule

// [sim/qa_watchdog_answer_evaluator_tb.sv]
// self-checking bench for the answer evaluator
`timescale 1ns/100ps
module qa_watchdog_answer_evaluator_tb;
  logic clock, reset, second_window_end, flag_clear, cycle_end, fail_count_up;
  logic fail_count_down, new_question, same_question, answer_error_flag, watchdog_error_flag;
  logic answer_strobe, answer_correct, first_response_window;
  logic [2:0] answer_count;
  logic [5:0] notes[$];
  logic [2:0] count_notes[$];
  logic [5:0] outcome;
  logic strobe_taken = 1'b0;
  logic [7:0] lfsr = 8'h25;
  int fails = 0, checks_done = 0;
  host_model host_model_inst (.clock(clock), .answer_strobe(answer_strobe),
    .answer_correct(answer_correct), .first_response_window(first_response_window));
  qa_watchdog_answer_evaluator qa_watchdog_answer_evaluator_inst (.clock(clock), .reset(reset),
    .answer_strobe(answer_strobe), .answer_correct(answer_correct),
    .first_response_window(first_response_window), .second_window_end(second_window_end),
    .flag_clear(flag_clear), .answer_count(answer_count), .answer_error_flag(answer_error_flag),
    .watchdog_error_flag(watchdog_error_flag), .cycle_end(cycle_end),
    .fail_count_up(fail_count_up), .fail_count_down(fail_count_down),
    .new_question(new_question), .same_question(same_question));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [7:0] step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task report_and_stop;
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task compare_end(input logic [5:0] e, input logic [5:0] g);
    checks_done++;
    if (e !== g) begin
      fails++;
      $display("Error %0t cycle end outcome %b expected %b", $time, g, e);
    end
  endtask
  task compare_count(input logic [2:0] e, input logic [2:0] g);
    checks_done++;
    if (e !== g) begin
      fails++;
      $display("Error %0t answer count %0d expected %0d", $time, g, e);
    end
  endtask
  assign outcome = {fail_count_up, fail_count_down, new_question, same_question,
    answer_error_flag, watchdog_error_flag};
  // an answer taken at this edge shows in the count right after it
  always @(posedge clock) strobe_taken <= answer_strobe === 1'b1;
  // sampled mid-cycle so registered outputs are settled
  always @(negedge clock) begin
    if (cycle_end === 1'b1) begin
      compare_end(notes.size() ? notes.pop_front() : 6'bx, outcome);
    end
    if (strobe_taken) begin
      compare_count(count_notes.size() ? count_notes.pop_front() : 3'bx, answer_count);
    end
  end
  task automatic run(input int n1, input int n2, input logic [3:0] bad);
    logic ok, aerr;
    aerr = |(bad & 4'((1 << (n1 + n2)) - 1));
    ok = n1 == 3 && n2 == 1 && !aerr;
    notes.push_back({!ok, ok, ok, !ok, aerr, !ok});
    for (int i = 0; i < n1 + n2; i++) begin
      count_notes.push_back(i == 3 ? 3'h0 : 3'(i + 1));
      host_model_inst.send(!bad[i], i < n1);
    end
    if (n1 + n2 < 4) begin
      @(posedge clock) #1 second_window_end = 1'b1;
      @(posedge clock) #1 second_window_end = 1'b0;
    end
    for (int k = 0; k < 10 && notes.size() + count_notes.size() > 0; k++) @(posedge clock);
    if (notes.size() + count_notes.size() > 0) begin
      fails++;
      report_and_stop;
    end else begin
      @(posedge clock) #1 flag_clear = 1'b1;
      @(posedge clock) #1 flag_clear = 1'b0;
    end
  endtask
  initial begin
    {reset, second_window_end, flag_clear} = 3'b100;
    repeat (20) @(posedge clock);
    #1 reset = 1'b0;
    run(3, 1, 4'h0);
    run(1, 3, 4'h0);
    run(1, 2, 4'h1);
    run(2, 2, 4'hc);
    run(0, 2, 4'h3);
    run(2, 1, 4'h0);
    run(3, 1, 4'h8);
    run(3, 1, 4'h0);
    repeat (8) begin
      lfsr = step(lfsr);
      run(lfsr[1:0], lfsr[3:2] > 4 - lfsr[1:0] ? 4 - lfsr[1:0] : lfsr[3:2], lfsr[7:4]);
    end
    report_and_stop;
  end
endmodule
